// File: rtl/gds_map.svh
// register offsets, opcodes, field positions and reset values of the dma command unit
`ifndef GDS_MAP_SVH
`define GDS_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define GDS_OFS_CMD 8'h30
`define GDS_OFS_CNT 8'h34
`define GDS_OFS_CFG 8'h38
`define GDS_OFS_POL 8'h3C
`define GDS_OFS_RSN 8'h40
`define GDS_OFS_ENA 8'h44
`define GDS_OFS_STS 8'h48
// ----------------------------------------
// command opcodes
// ----------------------------------------
`define GDS_OP_READ 8'h00
`define GDS_OP_WRITE 8'h01
`define GDS_OP_VALIDATE 8'h0E
`define GDS_OP_CLEAR 8'h0F
`define GDS_OP_RESET 8'h11
`define GDS_OP_STOP 8'h13
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define GDS_CMD_READBACK 32'h000000FF
`define GDS_CFG_RESET 16'h0001
`define GDS_CFG_WIDTH 0
`define GDS_CFG_MODE_LO 2
`define GDS_CFG_MODE_HI 3
`define GDS_CFG_CNT_DIS 7
`define GDS_MODE_STD 2'h0
`define GDS_POL_REQ 0
`define GDS_POL_ACK 1
`define GDS_POL_RESET 2'h3
`define GDS_RSN_EOT 0
`define GDS_RSN_CNT 1
`define GDS_RSN_STOP 2
`endif

// File: rtl/gds_pkg.sv
// types shared by the dma command unit
package gds_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_READ  = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_DRAIN = 4'b1000
   } gds_state_type;
endpackage

// File: rtl/gds_dma.sv
// generic dma slave command unit with avalon-mm register access
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "gds_map.svh"
// Behaviour
// R01: opcode 00h starts bus-to-buffer transfer
// R02: opcode 01h starts buffer-to-bus transfer
// R03: strobes routed to engine or register path
// R04: software keeps counter disable bit cleared
// R05: software loads counter before any command
// R06: counter updates only on most significant byte
// R07: count down; at zero flag and interrupt
// R08: end on eot, dma reset or stop
// R09: separate eot and count-complete reason bits
// R10: configuration bit selects 16 or 8 bits
// R11: request and acknowledge polarity bits
// R12: two-bit field selects active strobes
// R13: data bus undriven until command runs
// R14: command register write-only, reads ones
// R15: opcode 0Eh validates indexed endpoint buffer
// R16: opcode 0Fh clears transmit buffer only
// R17: transmit buffer auto-cleared after usb send
// R18: double buffer needs clear issued twice
// R19: opcode 11h resets whole dma core
// R20: start external controller after dma reset
// R21: stop halts; in fifo flushed to buffer
// R22: stop completion sets reason bit
// R23: counter readable, shows bytes remaining
// R24: in path fifo of eight bytes maximum
// R25: mode 00 standard strobes, others reserved
// R26: reserved opcode changes nothing
module gds_dma #(
   parameter int FIFO_DEPTH = 4 // words of two bytes
) (
   input wire logic i_clk_sys, // system clock
   input wire logic i_rst_b, // synchronous reset, active low
   input wire logic [7:0] i_avs_address, // avalon byte address
   input wire logic i_avs_read, // avalon read
   input wire logic i_avs_write, // avalon write
   input wire logic [3:0] i_avs_byteenable, // avalon byte enables
   input wire logic [31:0] i_avs_writedata, // avalon write data
   output logic [31:0] o_avs_readdata, // avalon read data
   output logic o_avs_waitrequest, // avalon wait
   input wire logic i_rd_strobe_b, // read strobe pin
   input wire logic i_wr_strobe_b, // write strobe pin
   input wire logic i_dma_acknowledge_pin, // acknowledge pin
   output logic o_dma_request_pin, // request pin
   input wire logic [15:0] i_dma_data, // data bus input
   output logic [15:0] o_dma_data, // data bus output
   output logic o_dma_data_oe, // data bus drive enable
   output logic o_pio_rd, // read strobe for register path
   output logic o_pio_wr, // write strobe for register path
   output logic [15:0] o_buf_wdata, // data into endpoint buffer
   output logic o_buf_wtwo, // both bytes valid
   output logic o_buf_wvalid, // buffer write valid
   input wire logic i_buf_wready, // buffer write ready
   input wire logic [15:0] i_buf_rdata, // data from endpoint buffer
   input wire logic i_buf_rvalid, // buffer read valid
   output logic o_buf_rready, // buffer read ready
   input wire logic i_out_short_eot, // short packet on out token
   input wire logic i_ep_tx_sent, // transmit data sent on usb
   output logic o_ep_validate, // validate indexed buffer
   output logic o_ep_tx_clear, // clear indexed transmit buffer
   output logic o_dma_irq, // dma interrupt
   output gds_pkg::gds_state_type o_engine_state // engine state
);
   import gds_pkg::*;
   localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
   localparam int CW = $clog2(FIFO_DEPTH + 1);

   // elaboration check of the fifo size
   if (FIFO_DEPTH < 1 || FIFO_DEPTH * 2 > 8 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_check
      $error("fifo depth must be a power of two of at most four words");
   end

   // ----------------------------------------
   // avalon slave
   // ----------------------------------------
   logic av_done;
   logic av_acc;
   logic core_rst;
   gds_state_type state;
   logic [31:0] counter;
   logic [23:0] cnt_stage;
   logic [15:0] cfg;
   logic [1:0] pol;
   logic [2:0] reason;
   logic [2:0] enable;
   logic [CW-1:0] fifo_cnt;
   logic cmd_we;
   logic [7:0] cmd;

   // one wait cycle, answer at the second edge
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         av_done <= 1'b0;
      end else begin
         av_done <= (i_avs_read | i_avs_write) & ~av_done;
      end
   end
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~av_done;
   assign av_acc = (i_avs_read | i_avs_write) & av_done;
   assign cmd = i_avs_writedata[7:0];
   assign cmd_we = av_acc & i_avs_write & (i_avs_address == `GDS_OFS_CMD) & i_avs_byteenable[0];
   assign core_rst = ~i_rst_b | (cmd_we & (cmd == `GDS_OP_RESET)); // R19

   // read data registered in the wait cycle
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_avs_readdata <= 32'h0;
      end else if (i_avs_read & ~av_done) begin
         unique case (i_avs_address)
            `GDS_OFS_CMD: o_avs_readdata <= `GDS_CMD_READBACK; // R14
            `GDS_OFS_CNT: o_avs_readdata <= counter; // R23
            `GDS_OFS_CFG: o_avs_readdata <= {16'h0, cfg};
            `GDS_OFS_POL: o_avs_readdata <= {30'h0, pol};
            `GDS_OFS_RSN: o_avs_readdata <= {29'h0, reason};
            `GDS_OFS_ENA: o_avs_readdata <= {29'h0, enable};
            `GDS_OFS_STS: o_avs_readdata <= {20'h0, 8'(fifo_cnt), 4'(state)};
            default: o_avs_readdata <= 32'h0;
         endcase
      end
   end

   // configuration, polarity and enable registers
   always_ff @(posedge i_clk_sys) begin
      if (core_rst) begin
         cfg <= `GDS_CFG_RESET;
         pol <= `GDS_POL_RESET;
         enable <= 3'h0;
      end else if (av_acc & i_avs_write) begin
         if (i_avs_address == `GDS_OFS_CFG && i_avs_byteenable[0]) begin
            cfg[7:0] <= i_avs_writedata[7:0];
         end
         if (i_avs_address == `GDS_OFS_CFG && i_avs_byteenable[1]) begin
            cfg[15:8] <= i_avs_writedata[15:8];
         end
         if (i_avs_address == `GDS_OFS_POL && i_avs_byteenable[0]) begin
            pol <= i_avs_writedata[1:0]; // R11
         end
         if (i_avs_address == `GDS_OFS_ENA && i_avs_byteenable[0]) begin
            enable <= i_avs_writedata[2:0]; // R09
         end
      end
   end

   // ----------------------------------------
   // pin synchronisers and strobe multiplex
   // ----------------------------------------
   logic rd_s1, rd_s2, rd_s3, wr_s1, wr_s2, wr_s3, ack_s1, ack_s2;
   logic [15:0] dat_s1, dat_s2;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         {rd_s1, rd_s2, rd_s3, wr_s1, wr_s2, wr_s3} <= 6'h3F;
         {ack_s1, ack_s2} <= 2'h0;
         {dat_s1, dat_s2} <= 32'h0;
      end else begin
         {rd_s1, rd_s2, rd_s3} <= {i_rd_strobe_b, rd_s1, rd_s2};
         {wr_s1, wr_s2, wr_s3} <= {i_wr_strobe_b, wr_s1, wr_s2};
         {ack_s1, ack_s2} <= {i_dma_acknowledge_pin, ack_s1};
         {dat_s1, dat_s2} <= {i_dma_data, dat_s1};
      end
   end

   logic busy, ack_on, mode_ok, rd_end, wr_end, rd_beat, wr_beat, wide, out_full;
   assign busy = (state == ST_READ) | (state == ST_WRITE);
   assign ack_on = (ack_s2 == pol[`GDS_POL_ACK]); // R11
   assign mode_ok = (cfg[`GDS_CFG_MODE_HI:`GDS_CFG_MODE_LO] == `GDS_MODE_STD); // R12 R25
   assign wide = cfg[`GDS_CFG_WIDTH]; // R10
   assign rd_end = ~rd_s3 & rd_s2;
   assign wr_end = ~wr_s3 & wr_s2;
   // strobes go to the engine while busy, otherwise to the register path
   assign o_pio_rd = rd_end & ~busy; // R03
   assign o_pio_wr = wr_end & ~busy; // R03

   // ----------------------------------------
   // in path fifo
   // ----------------------------------------
   logic [16:0] fifo_mem [FIFO_DEPTH];
   logic [PW-1:0] wp, rp;
   logic fifo_full, fifo_push, fifo_pop;
   assign fifo_full = (fifo_cnt == CW'(FIFO_DEPTH)); // R24
   assign wr_beat = (state == ST_READ) & mode_ok & ack_on & wr_end & ~fifo_full;
   assign rd_beat = (state == ST_WRITE) & mode_ok & ack_on & rd_end & out_full;
   assign fifo_push = wr_beat; // R01
   assign o_buf_wvalid = (fifo_cnt != '0);
   assign fifo_pop = o_buf_wvalid & i_buf_wready;
   assign o_buf_wdata = fifo_mem[rp][15:0];
   assign o_buf_wtwo = fifo_mem[rp][16];

   // fifo storage
   always_ff @(posedge i_clk_sys) begin
      if (fifo_push) begin
         fifo_mem[wp] <= {wide, wide ? dat_s2 : {8'h0, dat_s2[7:0]}};
      end
   end

   // fifo pointers and level
   always_ff @(posedge i_clk_sys) begin
      if (core_rst) begin
         wp <= '0;
         rp <= '0;
         fifo_cnt <= '0;
      end else begin
         wp <= fifo_push ? PW'(wp + 1'b1) : wp;
         rp <= fifo_pop ? PW'(rp + 1'b1) : rp;
         fifo_cnt <= CW'(fifo_cnt + CW'(fifo_push) - CW'(fifo_pop));
      end
   end

   // ----------------------------------------
   // out path holding word and bus drive
   // ----------------------------------------
   assign o_buf_rready = (state == ST_WRITE) & ~out_full; // R02
   always_ff @(posedge i_clk_sys) begin
      if (core_rst) begin
         out_full <= 1'b0;
         o_dma_data <= 16'h0;
      end else if (state != ST_WRITE) begin
         out_full <= 1'b0;
      end else if (o_buf_rready & i_buf_rvalid) begin
         out_full <= 1'b1;
         o_dma_data <= i_buf_rdata;
      end else if (rd_beat) begin
         out_full <= 1'b0;
      end
   end
   // bus driven only during a running buffer-to-bus transfer
   assign o_dma_data_oe = (state == ST_WRITE) & out_full & ~rd_s2 & ack_on & mode_ok; // R13

   // ----------------------------------------
   // byte counter
   // ----------------------------------------
   logic beat, cnt_on, cnt_last;
   logic [31:0] step;
   logic [23:0] next_stage;
   assign beat = wr_beat | rd_beat;
   assign cnt_on = ~cfg[`GDS_CFG_CNT_DIS]; // R04
   assign step = wide ? 32'h2 : 32'h1;
   assign cnt_last = beat & cnt_on & (counter <= step);
   // low three bytes stage until the top byte is written
   always_comb begin
      next_stage = cnt_stage;
      if (i_avs_byteenable[0]) begin
         next_stage[7:0] = i_avs_writedata[7:0];
      end
      if (i_avs_byteenable[1]) begin
         next_stage[15:8] = i_avs_writedata[15:8];
      end
      if (i_avs_byteenable[2]) begin
         next_stage[23:16] = i_avs_writedata[23:16];
      end
   end
   logic cnt_we;
   assign cnt_we = av_acc & i_avs_write & (i_avs_address == `GDS_OFS_CNT);
   always_ff @(posedge i_clk_sys) begin
      if (core_rst) begin
         cnt_stage <= 24'h0;
         counter <= 32'h0;
      end else begin
         if (cnt_we) begin
            cnt_stage <= next_stage;
         end
         if (cnt_we & i_avs_byteenable[3]) begin
            counter <= {i_avs_writedata[31:24], next_stage}; // R06
         end else if (beat & cnt_on) begin
            counter <= cnt_last ? 32'h0 : counter - step; // R07
         end
      end
   end

   // ----------------------------------------
   // engine state machine
   // ----------------------------------------
   logic stop_cmd, stop_pend, stop_done, eot_hit;
   assign stop_cmd = cmd_we & (cmd == `GDS_OP_STOP);
   assign eot_hit = i_out_short_eot & busy;
   always_ff @(posedge i_clk_sys) begin
      if (core_rst) begin
         state <= ST_IDLE; // R08
         stop_pend <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               stop_pend <= 1'b0;
               if (cmd_we && cmd == `GDS_OP_READ) begin
                  state <= ST_READ; // R01
               end else if (cmd_we && cmd == `GDS_OP_WRITE) begin
                  state <= ST_WRITE; // R02
               end
            end
            ST_READ: begin
               if (stop_cmd | eot_hit | cnt_last) begin
                  state <= ST_DRAIN; // R21
                  stop_pend <= stop_cmd;
               end
            end
            ST_WRITE: begin
               if (stop_cmd | eot_hit | cnt_last) begin
                  state <= ST_IDLE; // R08
               end
            end
            ST_DRAIN: begin
               if (fifo_cnt == '0) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end
   assign stop_done = (stop_cmd & (state == ST_WRITE)) | ((state == ST_DRAIN) & (fifo_cnt == '0) & stop_pend);
   assign o_engine_state = state;
   // request shown while the engine can take a beat
   assign o_dma_request_pin = ((state == ST_READ) & ~fifo_full & mode_ok) | ((state == ST_WRITE) & out_full & mode_ok)
                              ? pol[`GDS_POL_REQ] : ~pol[`GDS_POL_REQ]; // R11

   // ----------------------------------------
   // interrupt reasons, write one to clear, set wins
   // ----------------------------------------
   logic [2:0] rsn_set, rsn_clr;
   assign rsn_set = {stop_done, cnt_last, eot_hit}; // R09 R22
   assign rsn_clr = (av_acc & i_avs_write & (i_avs_address == `GDS_OFS_RSN) & i_avs_byteenable[0])
                    ? i_avs_writedata[2:0] : 3'h0;
   always_ff @(posedge i_clk_sys) begin
      if (core_rst) begin
         reason <= 3'h0;
      end else begin
         reason <= (reason & ~rsn_clr) | rsn_set; // R07
      end
   end
   assign o_dma_irq = |(reason & enable); // R07

   // ----------------------------------------
   // endpoint buffer commands
   // ----------------------------------------
   assign o_ep_validate = cmd_we & (cmd == `GDS_OP_VALIDATE); // R15
   assign o_ep_tx_clear = (cmd_we & (cmd == `GDS_OP_CLEAR)) | i_ep_tx_sent; // R16 R17

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   logic op_res;
   assign op_res = cmd_we && !(cmd inside {`GDS_OP_READ, `GDS_OP_WRITE, `GDS_OP_VALIDATE, `GDS_OP_CLEAR,
                                          `GDS_OP_RESET, `GDS_OP_STOP});
   property p_cmd_ones;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      i_avs_read && !o_avs_waitrequest && i_avs_address == `GDS_OFS_CMD |-> o_avs_readdata == `GDS_CMD_READBACK;
   endproperty
   a_cmd_ones: assert property (p_cmd_ones) else $error("command read not all ones"); // R14
   property p_start_rd;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      state == ST_IDLE && cmd_we && cmd == `GDS_OP_READ |=> state == ST_READ;
   endproperty
   a_start_rd: assert property (p_start_rd) else $error("read command did not start"); // R01
   property p_start_wr;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      state == ST_IDLE && cmd_we && cmd == `GDS_OP_WRITE |=> state == ST_WRITE && !out_full && !o_dma_data_oe;
   endproperty
   a_start_wr: assert property (p_start_wr) else $error("write command did not start"); // R02
   property p_reserved;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      op_res && state == ST_IDLE |=> $stable(state) && $stable(counter);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved opcode changed state"); // R26
   property p_count_done;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      cnt_last && !core_rst |=> counter == 32'h0 && reason[`GDS_RSN_CNT] && state != ST_READ && state != ST_WRITE;
   endproperty
   a_count_done: assert property (p_count_done) else $error("count end not flagged"); // R07
   property p_hiz;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      state != ST_WRITE |-> !o_dma_data_oe;
   endproperty
   a_hiz: assert property (p_hiz) else $error("data bus driven outside transfer"); // R13
   property p_cnt_hold;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      cnt_we && !i_avs_byteenable[3] && !beat |=> $stable(counter);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without top byte"); // R06
   property p_eot;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      eot_hit && !core_rst |=> reason[`GDS_RSN_EOT] && (state == ST_IDLE || state == ST_DRAIN);
   endproperty
   a_eot: assert property (p_eot) else $error("eot did not end transfer"); // R08
   property p_stop;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      stop_cmd && state == ST_WRITE |=> state == ST_IDLE && reason[`GDS_RSN_STOP];
   endproperty
   a_stop: assert property (p_stop) else $error("stop not completed"); // R22
   property p_reset;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      cmd_we && cmd == `GDS_OP_RESET |=> state == ST_IDLE && counter == 32'h0 && reason == 3'h0 && fifo_cnt == '0;
   endproperty
   a_reset: assert property (p_reset) else $error("dma reset incomplete"); // R19
   property p_fifo;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      fifo_cnt <= CW'(FIFO_DEPTH);
   endproperty
   a_fifo: assert property (p_fifo) else $error("fifo over eight bytes"); // R24
   property p_pio;
      @(posedge i_clk_sys) disable iff (!i_rst_b)
      busy |-> !o_pio_rd && !o_pio_wr;
   endproperty
   a_pio: assert property (p_pio) else $error("strobe reached register path in transfer"); // R03
endmodule
`default_nettype wire

// File: tb/gds_ext_dma.sv
// external dma controller model that paces the slave transfers
`timescale 1ns/100ps
`default_nettype none
module gds_ext_dma (
   input wire logic i_clk_sys, // system clock
   input wire logic i_dma_request_pin, // request from the device, active high
   input wire logic i_dma_data_oe, // device drives the bus
   input wire logic [15:0] i_dma_data, // device bus data
   output logic o_rd_strobe_b, // read strobe
   output logic o_wr_strobe_b, // write strobe
   output logic o_ack, // acknowledge, active high
   output logic [15:0] o_bus // resolved bus level
);
   logic [15:0] drv;
   // released bus shows the model's own level drv: the beat value during a beat, its inverse after the beat
   assign o_bus = i_dma_data_oe ? i_dma_data : drv;
   // idle levels at time zero
   initial begin
      o_rd_strobe_b = 1'b1;
      o_wr_strobe_b = 1'b1;
      o_ack = 1'b0;
      drv = 16'h0000;
   end
   // one beat, started on a request or after a wait of 300 cycles without one
   task automatic beat(input logic dir, input logic [15:0] d, input int slow, output logic [15:0] q);
      int n;
      n = 0;
      while (i_dma_request_pin !== 1'b1 && n < 300) begin
         @(posedge i_clk_sys);
         n++;
      end
      @(posedge i_clk_sys);
      o_ack <= 1'b1;
      drv <= d;
      repeat (slow) @(posedge i_clk_sys);
      if (dir) begin
         o_rd_strobe_b <= 1'b0;
      end else begin
         o_wr_strobe_b <= 1'b0;
      end
      repeat (6) @(posedge i_clk_sys);
      q = o_bus;
      o_rd_strobe_b <= 1'b1;
      o_wr_strobe_b <= 1'b1;
      // hold data and acknowledge well past the strobe end
      repeat (5) @(posedge i_clk_sys);
      o_ack <= 1'b0;
      drv <= ~d;
      @(posedge i_clk_sys);
   endtask
   // bare strobe pulse with no request pending
   task automatic strobe();
      @(posedge i_clk_sys);
      o_wr_strobe_b <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      o_wr_strobe_b <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
   endtask
endmodule
`default_nettype wire

// File: tb/gds_dma_bench.sv
// self-checking bench of the dma command unit
`timescale 1ns/100ps
`default_nettype none
`include "gds_map.svh"
`define CHK(a, e) begin \
   num_checks++; \
   if ((a) !== (e)) begin \
      fail_count++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); \
   end \
end
module gds_dma_bench;
   import gds_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] adr = 8'h00;
   logic avs_rd = 1'b0, avs_wr = 1'b0, wready = 1'b0, stall = 1'b0, brv = 1'b0, eot = 1'b0, txs = 1'b0;
   logic [3:0] be = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q, v;
   logic waitreq, rd_b, wr_b, ack, oe, req, pio_rd, pio_wr, bwv, bwtwo, brr, val, clr, irq;
   logic [15:0] bus, dout, bwd, bq, d, brd = 16'h0000;
   logic [15:0] src[$], sw[2];
   logic [16:0] got[$], exp[$], g, x;
   logic [7:0] ops[7] = '{8'h02, 8'h0D, 8'h10, 8'h12, 8'h14, 8'hFF, 8'h80};
   gds_state_type st;
   int fail_count = 0, num_checks = 0, val_cnt = 0, clr_cnt = 0, pio_cnt = 0, p, seed = 32'h2B00;
   gds_dma #(.FIFO_DEPTH(4)) DUT (
      .i_clk_sys(clk), .i_rst_b(rst_b), .i_avs_address(adr), .i_avs_read(avs_rd), .i_avs_write(avs_wr),
      .i_avs_byteenable(be), .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(waitreq),
      .i_rd_strobe_b(rd_b), .i_wr_strobe_b(wr_b), .i_dma_acknowledge_pin(ack), .o_dma_request_pin(req),
      .i_dma_data(bus), .o_dma_data(dout), .o_dma_data_oe(oe), .o_pio_rd(pio_rd), .o_pio_wr(pio_wr),
      .o_buf_wdata(bwd), .o_buf_wtwo(bwtwo), .o_buf_wvalid(bwv), .i_buf_wready(wready),
      .i_buf_rdata(brd), .i_buf_rvalid(brv), .o_buf_rready(brr), .i_out_short_eot(eot),
      .i_ep_tx_sent(txs), .o_ep_validate(val), .o_ep_tx_clear(clr), .o_dma_irq(irq), .o_engine_state(st));
   gds_ext_dma ext (.i_clk_sys(clk), .i_dma_request_pin(req), .i_dma_data_oe(oe), .i_dma_data(dout),
      .o_rd_strobe_b(rd_b), .o_wr_strobe_b(wr_b), .o_ack(ack), .o_bus(bus));
   always #5 clk = ~clk;
   // -----------------------------------------
   // endpoint buffer side and event monitors
   // -----------------------------------------
   // sink takes words with random stalls; counts one-cycle pulses
   always @(posedge clk) begin
      if (bwv === 1'b1 && wready === 1'b1) got.push_back({bwtwo, bwtwo ? bwd : {8'h00, bwd[7:0]}});
      wready <= ~stall & 1'($random(seed));
      val_cnt += (val === 1'b1);
      clr_cnt += (clr === 1'b1);
      pio_cnt += (pio_rd === 1'b1 || pio_wr === 1'b1);
   end
   // source offers queued words toward the bus
   always @(posedge clk) begin
      if (brv === 1'b1 && brr === 1'b1) void'(src.pop_front());
      brv <= (src.size() > 0);
      brd <= (src.size() > 0) ? src[0] : 16'h0000;
   end
   // -----------------------------------------
   // tasks
   // -----------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // avalon access held until waitrequest is seen low
   task automatic bus_op(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] dd);
      int n;
      n = 0;
      @(posedge clk);
      adr <= a;
      be <= b;
      wdat <= dd;
      avs_wr <= w;
      avs_rd <= ~w;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      q = rdat;
      avs_wr <= 1'b0;
      avs_rd <= 1'b0;
      if (n >= 50) fail_count++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dd);
      bus_op(1'b1, a, 4'hF, dd);
   endtask
   task automatic rd(input logic [7:0] a);
      bus_op(1'b0, a, 4'hF, 32'h0);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (st !== ST_IDLE && n < 400);
      `CHK(st, ST_IDLE)
   endtask
   task automatic cmp_q();
      `CHK(got.size(), exp.size())
      while (exp.size() > 0 && got.size() > 0) begin
         g = got.pop_front();
         x = exp.pop_front();
         `CHK(g, x)
      end
      got.delete();
      exp.delete();
   endtask
   // bus-to-buffer transfer under counter control
   task automatic run_in(input logic w, input int cnt);
      int k;
      k = 0;
      p = pio_cnt;
      wr(`GDS_OFS_CFG, {31'h0, w});
      wr(`GDS_OFS_CNT, cnt);
      wr(`GDS_OFS_CMD, `GDS_OP_READ);
      @(negedge clk);
      `CHK(st, ST_READ)
      `CHK(req, 1'b1)
      while (cnt > 0) begin
         d = 16'($random(seed));
         ext.beat(1'b0, d, k % 3, bq);
         exp.push_back({w, w ? d : {8'h00, d[7:0]}});
         cnt = (cnt > (w ? 2 : 1)) ? cnt - (w ? 2 : 1) : 0;
         k++;
         if (k == 1) begin
            rd(`GDS_OFS_CNT);
            `CHK(q, cnt)
         end
      end
      wait_idle();
      `CHK(pio_cnt, p)
      cmp_q();
      rd(`GDS_OFS_RSN);
      `CHK(q[2:0], 3'b010)
      `CHK(irq, 1'b1)
      wr(`GDS_OFS_RSN, 32'h7);
      @(negedge clk);
      `CHK(irq, 1'b0)
   endtask
   // -----------------------------------------
   // main sequence
   // -----------------------------------------
   initial begin
      repeat (30000) @(posedge clk);
      fail_count++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rd(`GDS_OFS_CMD);
      `CHK(q, 32'h000000FF)
      rd(8'h80);
      `CHK(q, 32'h0)
      rd(`GDS_OFS_CFG);
      `CHK(q, 32'h1)
      `CHK(oe, 1'b0)
      $display("test reset done");
      v = $random(seed);
      for (int i = 0; i < 3; i++) bus_op(1'b1, `GDS_OFS_CNT, 4'h1 << i, v);
      rd(`GDS_OFS_CNT);
      `CHK(q, 32'h0)
      bus_op(1'b1, `GDS_OFS_CNT, 4'h8, v);
      rd(`GDS_OFS_CNT);
      `CHK(q, v)
      $display("test counter bytes done");
      wr(`GDS_OFS_ENA, 32'h7);
      run_in(1'b1, 5);
      run_in(1'b0, 3);
      $display("test bus to buffer done");
      wr(`GDS_OFS_CFG, 32'h1);
      wr(`GDS_OFS_CNT, 32'h4);
      for (int i = 0; i < 2; i++) sw[i] = 16'($random(seed));
      src.push_back(sw[0]);
      src.push_back(sw[1]);
      wr(`GDS_OFS_CMD, `GDS_OP_WRITE);
      @(negedge clk);
      `CHK(st, ST_WRITE)
      for (int i = 0; i < 2; i++) begin
         ext.beat(1'b1, ~sw[i], i, bq);
         `CHK(bq, sw[i])
      end
      wait_idle();
      `CHK(oe, 1'b0)
      rd(`GDS_OFS_RSN);
      `CHK(q[2:0], 3'b010)
      wr(`GDS_OFS_RSN, 32'h7);
      $display("test buffer to bus done");
      for (int m = 0; m < 2; m++) begin
         stall <= m[0];
         wr(`GDS_OFS_CNT, 32'h100);
         wr(`GDS_OFS_CMD, `GDS_OP_READ);
         d = 16'($random(seed));
         ext.beat(1'b0, d, 1, bq);
         exp.push_back({1'b1, d});
         if (m == 1) begin
            wr(`GDS_OFS_CMD, `GDS_OP_STOP);
         end else begin
            @(posedge clk);
            eot <= 1'b1;
            @(posedge clk);
            eot <= 1'b0;
         end
         stall <= 1'b0;
         wait_idle();
         cmp_q();
         rd(`GDS_OFS_RSN);
         `CHK(q[2:0], (m == 1) ? 3'b100 : 3'b001)
         wr(`GDS_OFS_RSN, 32'h7);
      end
      $display("test end and stop done");
      wr(`GDS_OFS_CMD, `GDS_OP_VALIDATE);
      wr(`GDS_OFS_CMD, `GDS_OP_CLEAR);
      wr(`GDS_OFS_CMD, `GDS_OP_CLEAR);
      @(negedge clk);
      `CHK(val_cnt, 1)
      `CHK(clr_cnt, 2)
      @(posedge clk);
      txs <= 1'b1;
      @(posedge clk);
      txs <= 1'b0;
      @(negedge clk);
      `CHK(clr_cnt, 3)
      ops[6] = 8'h80 | 8'($random(seed));
      foreach (ops[i]) begin
         wr(`GDS_OFS_CMD, {24'h0, ops[i]});
         @(negedge clk);
         `CHK(st, ST_IDLE)
         `CHK(req, 1'b0)
      end
      rd(`GDS_OFS_RSN);
      `CHK(q, 32'h0)
      $display("test buffer and reserved commands done");
      p = pio_cnt;
      ext.strobe();
      `CHK(pio_cnt, p + 1)
      wr(`GDS_OFS_CFG, 32'h5);
      wr(`GDS_OFS_CNT, 32'h4);
      wr(`GDS_OFS_CMD, {24'h0, `GDS_OP_WRITE});
      repeat (10) @(negedge clk);
      `CHK(req, 1'b0)
      wr(`GDS_OFS_CMD, `GDS_OP_STOP);
      wait_idle();
      wr(`GDS_OFS_POL, 32'h0);
      @(negedge clk);
      `CHK(req, 1'b1)
      wr(`GDS_OFS_CFG, 32'h80);
      wr(`GDS_OFS_CMD, `GDS_OP_RESET);
      rd(`GDS_OFS_CFG);
      `CHK(q, 32'h1)
      rd(`GDS_OFS_POL);
      `CHK(q, 32'h3)
      rd(`GDS_OFS_CNT);
      `CHK(q, 32'h0)
      `CHK(req, 1'b0)
      $display("test modes and core reset done");
      print_verdict();
   end
endmodule
`default_nettype wire
